// ### shared/cwu_map.svh
// Register offsets, field positions and reset values of the waveform steering unit
`ifndef CWU_MAP_SVH
`define CWU_MAP_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define CWU_OFS_CTRL 3'h0
`define CWU_OFS_POL 3'h1
`define CWU_OFS_DBR 3'h2
`define CWU_OFS_DBF 3'h3
`define CWU_OFS_SDC 3'h4
`define CWU_OFS_SRC 3'h5
`define CWU_OFS_STEER 3'h6
`define CWU_OFS_FIX 3'h7

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CWU_EN_BIT 7
`define CWU_DIR_BIT 0
`define CWU_IN_BIT 5
`define CWU_SHUT_BIT 7
`define CWU_REN_BIT 6
`define CWU_OVERRIDE_LEVEL_BD_LSB 4
`define CWU_OVERRIDE_LEVEL_AC_LSB 2

// ----------------------------------------
// Reset values
// ----------------------------------------
`define CWU_RST_CTRL 8'h00
`define CWU_RST_POL 4'h0
`define CWU_RST_DB 6'h00
`define CWU_RST_OVERRIDE_LEVEL_BD 2'h1
`define CWU_RST_OVERRIDE_LEVEL_AC 2'h1
`define CWU_RST_SRC 6'h00
`define CWU_RST_STEER 4'h0
`define CWU_RST_FIX 4'h0

`endif

// ### shared/cwu_pkg.sv
// Types shared by the waveform steering unit
package cwu_pkg;

  typedef enum logic [2:0] {
    CWU_MODE_STEER = 3'h0,
    CWU_MODE_SSTEER = 3'h1,
    CWU_MODE_FWD = 3'h2,
    CWU_MODE_REV = 3'h3,
    CWU_MODE_HALF = 3'h4,
    CWU_MODE_PP = 3'h5
  } cwu_mode_t;

  typedef enum logic [1:0] {
    CWU_OVR_INACT = 2'h0,
    CWU_OVR_HIZ = 2'h1,
    CWU_OVR_LOW = 2'h2,
    CWU_OVR_HIGH = 2'h3
  } cwu_ovr_t;

  // One-bit steps run -> shut -> hold; hold -> run flips both bits
  typedef enum logic [1:0] {
    CWU_ST_RUN = 2'h0,
    CWU_ST_SHUT = 2'h1,
    CWU_ST_HOLD = 2'h3
  } cwu_state_t;

endpackage

// ### src/cwu_sync.sv
// Two-flop synchroniser, one chain per bit
module cwu_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rstn_in,
  // Data
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta_ff;

  generate
    for (genvar i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
          meta_ff[i] <= 1'b0;
          sync_out[i] <= 1'b0;
        end else begin
          meta_ff[i] <= async_in[i];
          sync_out[i] <= meta_ff[i];
        end
      end
    end
  endgenerate

endmodule

// ### src/cwu_steer.sv
// Output steering, full-bridge direction and auto-shutdown of the waveform unit
//
// Summary of operation
// (RL1) Direction write applies at next input rise
// (RL2) New modulated output waits dead band once
// (RL3) Steering modes allow any output subset
// (RL4) Unsteered output fixed, steered follows input
// (RL5) Inversion acts only on steered outputs
// (RL6) Shutdown overrides only steered outputs
// (RL7) Mode 000 steering change applies immediately
// (RL8) Mode 001 steering change at input rise
// (RL9) Software set of shutdown flag forces override
// (RL10) Without auto-restart flag stays until cleared
// (RL11) Auto-restart clears flag when sources idle
// (RL12) Enabled fault input overrides outputs at once
// (RL13) Six individually enabled shutdown sources
// (RL14) Shutdown sources act by level
// (RL15) Software clear fails while source active
// (RL16) Override holds until first rise after clear
// (RL17) Two override fields, polarity ignored
// (RL18) Keeps running while processor sleeps
// (RL19) Software configures disabled, shutdown set first
// (RL20) Software starts via auto-restart or clear
// (RL21) Mode field decode of eight values
// (RL22) Override encoding high, low, float, inactive
// (RL23) Shutdown flag writable while disabled
// (RL24) Per-output fixed level bit
// (RL25) Flag reads set in shut state only; reads clear while override holds to next rise
//
// The register addresses and the plain strobed port are this design's own decisions.
module cwu_steer
  import cwu_pkg::*;
#(
  parameter int DB_W = 6
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rstn_in,
  // Register port
  input wire logic [2:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  // Modulating input and shutdown sources
  input wire logic data_in,
  input wire logic cmp1_in,
  input wire logic cmp2_in,
  input wire logic tmr_a_in,
  input wire logic tmr_b_in,
  input wire logic tmr_c_in,
  input wire logic wave_pin_in,
  // Outputs a, b, c, d on bits 0 to 3
  output logic [3:0] out_val_out,
  output logic [3:0] out_oe_out
);
  import cwu_pkg::*;
  `include "cwu_map.svh"

  // ----------------------------------------
  // Parameter check
  // ----------------------------------------
  generate
    if (DB_W < 1 || DB_W > 8) begin : g_bad_db
      $error("DB_W must lie between 1 and 8");
    end
  endgenerate

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [6:0] raw_s;
  logic data_s;
  logic [5:0] src_s;

  cwu_sync #(.W(7)) u_sync (
    .mclk_in(mclk_in),
    .rstn_in(rstn_in),
    .async_in({wave_pin_in, tmr_c_in, tmr_b_in, tmr_a_in, cmp2_in, cmp1_in, data_in}),
    .sync_out(raw_s)
  );
  assign data_s = raw_s[0];
  assign src_s = raw_s[6:1];

  logic data_prev_ff;
  logic rise;

  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      data_prev_ff <= 1'b0;
    end else begin
      data_prev_ff <= data_s;
    end
  end
  assign rise = data_s & ~data_prev_ff;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic en_ff;
  cwu_mode_t mode_ff;
  logic [3:0] pol_ff;
  logic [DB_W-1:0] dbr_ff;
  logic [DB_W-1:0] dbf_ff;
  logic ren_ff;
  logic [1:0] override_level_bd_ff;
  logic [1:0] override_level_ac_ff;
  logic [5:0] src_en_ff;
  logic [3:0] steer_ff;
  logic [3:0] fix_ff;
  logic wr_sdc;

  assign wr_sdc = wr_in && (addr_in == `CWU_OFS_SDC);

  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      en_ff <= 1'(`CWU_RST_CTRL >> `CWU_EN_BIT);
      mode_ff <= CWU_MODE_STEER;
      pol_ff <= `CWU_RST_POL;
      dbr_ff <= DB_W'(`CWU_RST_DB);
      dbf_ff <= DB_W'(`CWU_RST_DB);
      ren_ff <= 1'b0;
      override_level_bd_ff <= `CWU_RST_OVERRIDE_LEVEL_BD;
      override_level_ac_ff <= `CWU_RST_OVERRIDE_LEVEL_AC;
      src_en_ff <= `CWU_RST_SRC;
      steer_ff <= `CWU_RST_STEER;
      fix_ff <= `CWU_RST_FIX;
    end else if (wr_in) begin
      case (addr_in)
        `CWU_OFS_CTRL: begin
          en_ff <= wdata_in[`CWU_EN_BIT];
          mode_ff <= cwu_mode_t'(wdata_in[2:0]); // RL21
        end
        `CWU_OFS_POL: pol_ff <= wdata_in[3:0];
        `CWU_OFS_DBR: dbr_ff <= wdata_in[DB_W-1:0];
        `CWU_OFS_DBF: dbf_ff <= wdata_in[DB_W-1:0];
        `CWU_OFS_SDC: begin
          ren_ff <= wdata_in[`CWU_REN_BIT];
          override_level_bd_ff <= wdata_in[`CWU_OVERRIDE_LEVEL_BD_LSB +: 2];
          override_level_ac_ff <= wdata_in[`CWU_OVERRIDE_LEVEL_AC_LSB +: 2];
        end
        `CWU_OFS_SRC: src_en_ff <= wdata_in[5:0]; // RL13
        `CWU_OFS_STEER: steer_ff <= wdata_in[3:0];
        `CWU_OFS_FIX: fix_ff <= wdata_in[3:0]; // RL24
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // Shutdown state
  // ----------------------------------------
  // Sources count as asserted when high; they are level sensed, never latched
  logic src_act;
  logic sw_set;
  logic sw_clr;
  cwu_state_t st_ff;
  cwu_state_t nxt_st;

  assign src_act = |(src_s & src_en_ff); // RL14
  // Accepted regardless of enable so software can arm shutdown before start
  assign sw_set = wr_sdc && wdata_in[`CWU_SHUT_BIT]; // RL23
  assign sw_clr = wr_sdc && !wdata_in[`CWU_SHUT_BIT];

  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      CWU_ST_RUN: begin
        if (sw_set || src_act) begin
          nxt_st = CWU_ST_SHUT; // RL9
        end
      end
      CWU_ST_SHUT: begin
        // Set wins: a source or a set write keeps the flag
        if (!src_act && !sw_set && (ren_ff || sw_clr)) begin
          nxt_st = CWU_ST_HOLD; // RL10 RL11 RL15
        end
      end
      CWU_ST_HOLD: begin
        if (sw_set || src_act) begin
          nxt_st = CWU_ST_SHUT;
        end else if (rise) begin
          nxt_st = CWU_ST_RUN; // RL16
        end
      end
      default: nxt_st = CWU_ST_RUN;
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      st_ff <= CWU_ST_RUN;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------
  // Steering selection
  // ----------------------------------------
  logic [3:0] steer_sync_ff;
  logic [3:0] steer_eff;

  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      steer_sync_ff <= `CWU_RST_STEER;
    end else if (mode_ff != CWU_MODE_SSTEER || rise) begin
      steer_sync_ff <= steer_ff; // RL8
    end
  end
  // Asynchronous mode may chop the pulse in flight; useful to pull a pin fast
  assign steer_eff = (mode_ff == CWU_MODE_STEER) ? steer_ff : steer_sync_ff; // RL7

  // ----------------------------------------
  // Full-bridge direction and dead band
  // ----------------------------------------
  logic fb_mode;
  logic dir_ff;
  logic db_busy_ff;
  logic [DB_W-1:0] db_cnt_ff;
  logic [DB_W-1:0] db_tgt_ff;
  logic dir_chg;

  assign fb_mode = (mode_ff == CWU_MODE_FWD) || (mode_ff == CWU_MODE_REV);
  assign dir_chg = fb_mode && rise && (mode_ff[`CWU_DIR_BIT] != dir_ff);

  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      dir_ff <= 1'b0;
    end else if (!fb_mode || rise) begin
      dir_ff <= mode_ff[`CWU_DIR_BIT]; // RL1
    end
  end

  // Counts from zero to the band value; only the first pulse is delayed
  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      db_busy_ff <= 1'b0;
      db_cnt_ff <= '0;
      db_tgt_ff <= '0;
    end else if (dir_chg) begin
      db_cnt_ff <= '0;
      db_tgt_ff <= mode_ff[`CWU_DIR_BIT] ? dbr_ff : dbf_ff;
      db_busy_ff <= ((mode_ff[`CWU_DIR_BIT] ? dbr_ff : dbf_ff) != '0); // RL2
    end else if (db_busy_ff) begin
      db_cnt_ff <= db_cnt_ff + 1'b1;
      db_busy_ff <= (db_cnt_ff + 1'b1) != db_tgt_ff;
    end
  end

  // ----------------------------------------
  // Output composition
  // ----------------------------------------
  logic ovr;
  logic [3:0] nxt_val;
  logic [3:0] nxt_oe;

  assign ovr = (st_ff != CWU_ST_RUN) || src_act; // RL12

  always_comb begin
    logic act;
    logic [1:0] lvl;
    act = 1'b0;
    lvl = 2'h0;
    nxt_val = '0;
    nxt_oe = '0;
    for (int i = 0; i < 4; i++) begin
      lvl = (i % 2 == 0) ? override_level_ac_ff : override_level_bd_ff;
      act = 1'b1;
      case (mode_ff)
        CWU_MODE_STEER, CWU_MODE_SSTEER: begin
          act = steer_eff[i]; // RL6
          nxt_val[i] = steer_eff[i] ? (data_s ^ pol_ff[i]) : fix_ff[i]; // RL3 RL4 RL5
        end
        CWU_MODE_FWD, CWU_MODE_REV: begin
          if (i == (dir_ff ? 2 : 0)) begin
            nxt_val[i] = ~pol_ff[i];
          end else if (i == (dir_ff ? 1 : 3)) begin
            nxt_val[i] = (data_s & ~db_busy_ff) ^ pol_ff[i]; // RL2
          end else begin
            nxt_val[i] = pol_ff[i];
          end
        end
        // Bridge pairs without dead band; push-pull sequencing not built
        default: nxt_val[i] = (data_s ^ i[0]) ^ pol_ff[i];
      endcase
      nxt_oe[i] = en_ff;
      if (ovr && act) begin
        case (cwu_ovr_t'(lvl))
          CWU_OVR_HIGH: nxt_val[i] = 1'b1; // RL17 RL22
          CWU_OVR_LOW: nxt_val[i] = 1'b0;
          CWU_OVR_HIZ: begin
            nxt_val[i] = 1'b0;
            nxt_oe[i] = 1'b0;
          end
          default: nxt_val[i] = pol_ff[i];
        endcase
      end
      if (!en_ff) begin
        nxt_val[i] = 1'b0;
      end
    end
  end

  // No sleep gating: the unit runs whenever its clock runs
  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      out_val_out <= '0;
      out_oe_out <= '0;
    end else begin
      out_val_out <= nxt_val; // RL18
      out_oe_out <= nxt_oe;
    end
  end

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  logic [7:0] nxt_rdata;

  always_comb begin
    nxt_rdata = '0;
    case (addr_in)
      `CWU_OFS_CTRL: nxt_rdata = {en_ff, 4'h0, mode_ff};
      `CWU_OFS_POL: nxt_rdata = {2'h0, data_s, 1'b0, pol_ff};
      `CWU_OFS_DBR: nxt_rdata = 8'(dbr_ff);
      `CWU_OFS_DBF: nxt_rdata = 8'(dbf_ff);
      `CWU_OFS_SDC: nxt_rdata = {st_ff == CWU_ST_SHUT, ren_ff, override_level_bd_ff, override_level_ac_ff, 2'h0}; // RL25
      `CWU_OFS_SRC: nxt_rdata = {1'b1, 1'b0, src_en_ff};
      `CWU_OFS_STEER: nxt_rdata = {4'h0, steer_ff};
      `CWU_OFS_FIX: nxt_rdata = {4'h0, fix_ff};
      default: nxt_rdata = '0;
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      rdata_out <= '0;
    end else if (rd_in) begin
      rdata_out <= nxt_rdata;
    end else begin
      rdata_out <= '0;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  sequence s_flag_drop;
    st_ff == CWU_ST_SHUT ##1 st_ff == CWU_ST_HOLD;
  endsequence

  property p_sw_set;
    @(posedge mclk_in) disable iff (!rstn_in) sw_set |=> st_ff == CWU_ST_SHUT;
  endproperty
  a_sw_set: assert property (p_sw_set) else $error("shutdown write not taken"); // RL9

  property p_clr_blocked;
    @(posedge mclk_in) disable iff (!rstn_in)
      st_ff == CWU_ST_SHUT && !ren_ff && sw_clr && src_act |=> st_ff == CWU_ST_SHUT;
  endproperty
  a_clr_blocked: assert property (p_clr_blocked) else $error("clear passed active source"); // RL15

  property p_auto_restart;
    @(posedge mclk_in) disable iff (!rstn_in)
      st_ff == CWU_ST_SHUT && ren_ff && !src_act && !sw_set |=> st_ff == CWU_ST_HOLD;
  endproperty
  a_auto_restart: assert property (p_auto_restart) else $error("auto restart missed"); // RL11

  property p_hold_until_rise;
    @(posedge mclk_in) disable iff (!rstn_in)
      s_flag_drop ##0 !rise |=> st_ff != CWU_ST_RUN;
  endproperty
  a_hold_until_rise: assert property (p_hold_until_rise) else $error("override left early"); // RL16

  property p_no_restart;
    @(posedge mclk_in) disable iff (!rstn_in)
      st_ff == CWU_ST_SHUT && !ren_ff && !wr_sdc |=> st_ff == CWU_ST_SHUT;
  endproperty
  a_no_restart: assert property (p_no_restart) else $error("flag cleared by itself"); // RL10

  property p_fault_fast;
    @(posedge mclk_in) disable iff (!rstn_in)
      en_ff && src_act && !mode_ff[2] && !mode_ff[1] && steer_eff[0] && override_level_ac_ff == 2'h3
      |=> out_val_out[0] && out_oe_out[0];
  endproperty
  a_fault_fast: assert property (p_fault_fast) else $error("fault override late"); // RL12

  property p_fixed;
    @(posedge mclk_in) disable iff (!rstn_in)
      en_ff && mode_ff[2:1] == 2'h0 && !steer_eff[1] |=> out_val_out[1] == $past(fix_ff[1]);
  endproperty
  a_fixed: assert property (p_fixed) else $error("fixed level wrong"); // RL4

  property p_async_steer;
    @(posedge mclk_in) disable iff (!rstn_in)
      wr_in && addr_in == `CWU_OFS_STEER && mode_ff == CWU_MODE_STEER
      |=> steer_eff == $past(wdata_in[3:0]);
  endproperty
  a_async_steer: assert property (p_async_steer) else $error("steer change late"); // RL7

  property p_sync_steer;
    @(posedge mclk_in) disable iff (!rstn_in)
      mode_ff == CWU_MODE_SSTEER && !rise ##1 mode_ff == CWU_MODE_SSTEER
      |-> $stable(steer_sync_ff);
  endproperty
  a_sync_steer: assert property (p_sync_steer) else $error("steer change off edge"); // RL8

  property p_dir_on_rise;
    @(posedge mclk_in) disable iff (!rstn_in)
      fb_mode && $changed(dir_ff) |-> $past(rise) && $past(fb_mode);
  endproperty
  a_dir_on_rise: assert property (p_dir_on_rise) else $error("direction off edge"); // RL1

endmodule

// ### test/cwu_gate_model.sv
// Model of the gate drivers and fault sources around the waveform unit
module cwu_gate_model (
  // Clock
  input wire logic mclk_in,
  // Fault commands from the bench
  input wire logic [5:0] fault_cmd_in,
  // Unit outputs
  input wire logic [3:0] out_val_in,
  input wire logic [3:0] out_oe_in,
  // Fault lines and pin levels
  output logic [5:0] src_out,
  output logic [3:0] pin_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] last_ff = 4'h0;
  // ----------
  // Fault lines
  // ----------
  // Levels are held, never pulsed, so a stuck fault stays visible
  assign src_out = fault_cmd_in;
  // ----------
  // Pin levels
  // ----------
  // No pull on the pins: a released pin toggles so it never looks driven
  assign pin_out = (out_oe_in & out_val_in) | (~out_oe_in & ~last_ff);
  always_ff @(posedge mclk_in) begin
    last_ff <= pin_out;
  end
endmodule

// ### test/waveform_steering_and_shutdown_tb_top.sv
// Self-checking bench of the waveform steering and shutdown unit
module waveform_steering_and_shutdown_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------
  // Stimulus, model state and counters
  // ----------
  logic mclk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic [2:0] addr_in = 3'h0;
  logic [7:0] wdata_in = 8'h00;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic data_in = 1'b0;
  logic [5:0] fault_cmd = 6'h00;
  logic [5:0] src;
  logic [7:0] rdata_out;
  logic [3:0] out_val_out;
  logic [3:0] out_oe_out;
  logic [7:0] rd_v;
  logic [3:0] steer = 4'h0;
  logic [3:0] fix = 4'h0;
  logic [3:0] pol = 4'h0;
  logic [1:0] override_level_ac = 2'h1;
  logic [1:0] override_level_bd = 2'h1;
  logic [2:0] mode = 3'h0;
  logic en = 1'b0;
  logic ov = 1'b0;
  logic dv = 1'b0;
  int miscompares = 0;
  int samples_checked = 0;
  int cycles = 0;

  cwu_steer dut (
    .mclk_in(mclk_in), .rstn_in(rstn_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .data_in(data_in),
    .cmp1_in(src[0]), .cmp2_in(src[1]), .tmr_a_in(src[2]), .tmr_b_in(src[3]),
    .tmr_c_in(src[4]), .wave_pin_in(src[5]), .out_val_out(out_val_out),
    .out_oe_out(out_oe_out)
  );
  cwu_gate_model partner (
    .mclk_in(mclk_in), .fault_cmd_in(fault_cmd), .out_val_in(out_val_out),
    .out_oe_in(out_oe_out), .src_out(src), .pin_out()
  );

  always #5 mclk_in = ~mclk_in;

  // Ceiling over three times the expected run, so a hang ends quickly
  always @(posedge mclk_in) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      end_sim();
    end
  end
  // ----------
  // Tasks and reference model
  // ----------
  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_in);
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge mclk_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a);
    @(posedge mclk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge mclk_in);
    rd_in <= 1'b0;
    #1 rd_v = rdata_out;
  endtask
  task automatic din(input logic v);
    @(posedge mclk_in);
    data_in <= v;
    dv = v;
  endtask
  task automatic rise();
    din(1'b0);
    cyc(3);
    din(1'b1);
  endtask
  task automatic fault(input logic [5:0] f);
    @(posedge mclk_in);
    fault_cmd <= f;
  endtask
  task automatic sdc(input logic s, input logic r, input logic [1:0] bd, input logic [1:0] ac);
    override_level_bd = bd;
    override_level_ac = ac;
    wr(3'h4, {s, r, bd, ac, 2'h0});
  endtask
  task automatic flag(input logic f);
    rd(3'h4);
    chk("shutdown flag", {7'h0, rd_v[7]}, {7'h0, f});
  endtask
  function automatic logic [7:0] model();
    logic [3:0] v;
    logic [3:0] e;
    logic [1:0] lv;
    for (int i = 0; i < 4; i++) begin
      lv = i[0] ? override_level_bd : override_level_ac;
      e[i] = en;
      if (mode < 3'h2) begin
        v[i] = steer[i] ? dv ^ pol[i] : fix[i];
      end else if (mode > 3'h3) begin
        v[i] = dv ^ i[0] ^ pol[i];
      end else if (i == (mode[0] ? 2 : 0)) begin
        v[i] = ~pol[i];
      end else if (i == (mode[0] ? 1 : 3)) begin
        v[i] = dv ^ pol[i];
      end else begin
        v[i] = pol[i];
      end
      if (ov && (mode > 3'h1 || steer[i])) begin
        v[i] = (lv == 2'h0) ? pol[i] : lv[0];
        e[i] = en && (lv != 2'h1);
      end
    end
    return {e, v & e};
  endfunction
  task automatic chk_out(input string what);
    cyc(6);
    #1 chk(what, {out_oe_out, out_val_out & out_oe_out}, model());
  endtask
  // ----------
  // Main sequence
  // ----------
  initial begin
    void'($urandom(63162));
    cyc(10);
    rstn_in <= 1'b1;
    for (int a = 0; a < 8; a++) begin
      rd(a[2:0]);
      chk("reset value", rd_v, (a == 4) ? 8'h14 : ((a == 5) ? 8'h80 : 8'h00));
    end
    wr(3'h6, 8'h0f);
    steer = 4'hf;
    sdc(1'b1, 1'b0, 2'h1, 2'h1);
    flag(1'b1);
    ov = 1'b1;
    chk_out("disabled");
    wr(3'h0, 8'h80);
    en = 1'b1;
    chk_out("start in shutdown");
    sdc(1'b0, 1'b0, 2'h1, 2'h1);
    rise();
    ov = 1'b0;
    chk_out("started");
    repeat (8) begin
      steer = 4'($urandom);
      fix = 4'($urandom);
      pol = 4'($urandom);
      wr(3'h7, {4'h0, fix});
      wr(3'h1, {4'h0, pol});
      wr(3'h6, {4'h0, steer});
      din(1'b0);
      chk_out("steer low");
      din(1'b1);
      chk_out("steer high");
    end
    steer = ~steer;
    wr(3'h6, {4'h0, steer});
    chk_out("immediate steer");
    wr(3'h0, 8'h81);
    mode = 3'h1;
    wr(3'h6, {4'h0, ~steer});
    chk_out("steer waits");
    rise();
    steer = ~steer;
    chk_out("steer at rise");
    for (int c = 0; c < 4; c++) begin
      sdc(1'b1, 1'b0, c[1:0], ~c[1:0]);
      ov = 1'b1;
      chk_out("sw shutdown");
      cyc(30);
      flag(1'b1);
      sdc(1'b0, 1'b0, c[1:0], ~c[1:0]);
      chk_out("hold after clear");
      rise();
      ov = 1'b0;
      chk_out("resume");
    end
    // Steer a and c only, drive them high on a fault, keep b and d fixed
    wr(3'h0, 8'h80);
    mode = 3'h0;
    steer = 4'h5;
    wr(3'h6, {4'h0, steer});
    sdc(1'b0, 1'b0, 2'h2, 2'h3);
    for (int s = 0; s < 6; s++) begin
      wr(3'h5, 8'(1 << s));
      fault(~6'(1 << s));
      chk_out("masked sources");
      fault(6'h3f);
      ov = 1'b1;
      chk_out("fault override");
      sdc(1'b0, 1'b0, override_level_bd, override_level_ac);
      flag(1'b1);
      fault(6'h00);
      cyc(4);
      sdc(1'b0, 1'b0, override_level_bd, override_level_ac);
      flag(1'b0);
      chk_out("fault hold");
      rise();
      ov = 1'b0;
      chk_out("fault resume");
    end
    wr(3'h5, 8'h01);
    sdc(1'b0, 1'b1, override_level_bd, override_level_ac);
    fault(6'h01);
    ov = 1'b1;
    chk_out("auto shutdown");
    fault(6'h00);
    cyc(6);
    flag(1'b0);
    rise();
    ov = 1'b0;
    chk_out("auto resume");
    sdc(1'b0, 1'b0, override_level_bd, override_level_ac);
    wr(3'h1, 8'h00);
    pol = 4'h0;
    wr(3'h0, 8'h82);
    mode = 3'h2;
    rise();
    chk_out("forward bridge");
    wr(3'h2, 8'h14);
    wr(3'h3, 8'h14);
    wr(3'h0, 8'h83);
    chk_out("direction waits");
    din(1'b0);
    cyc(6);
    din(1'b1);
    mode = 3'h3;
    cyc(6);
    #1 chk("dead band", {out_oe_out, out_val_out & out_oe_out}, model() & 8'hfd);
    cyc(24);
    chk_out("reverse bridge");
    wr(3'h0, 8'h84);
    mode = 3'h4;
    chk_out("half bridge");
    wr(3'h0, 8'h85);
    mode = 3'h5;
    chk_out("push pull");
    rd(3'h0);
    chk("mode readback", rd_v, 8'h85);
    end_sim();
  end
endmodule
